// ==== hdl/bccc_regs.vh ====
//////////////////////////////////////////////////////////////////////////////
// Purpose : Constants of the BCD calendar clock core
// Assumes : 10 MHz reference clock, 65536 Hz internal sub-tick
// Notes   : Included by every design file of the core
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - A 56-bit BCD calendar holds year, month, day, weekday, hour, minute, second.
// - Calendar bits move LSB first, starting at the year field, then in order.
// - Mode status is 8 bits; supply-low flag read-only, others read/write.
// - Alarm-or-frequency register is 16-bit write-only; status bits choose its meaning.
// - With alarm enabled it holds BCD hour and minute like the calendar fields.
// - With frequency enabled every set bit picks a frequency; picks are ANDed.
// - Test flag sits in the seconds MSB; test start sets it, end clears.
// - Power-on loads status 82h and alarm register 8000h, giving 1 Hz out.
// - Supply-low flag sets at power-on or supply drop and stays set until the reset command.
// - Initialisation sets calendar to 00-01-01, weekday 0, 00:00:00.
// - Written fields except seconds are validated; bad values become 00, 01 or 0.
// - Hours 0-23 or 0-11; in 24-hour mode meridiem reads as afternoon for hours 12-23.
// - Bad seconds are fixed at the next carry, which also advances minutes.
// - A non-existent day becomes the first of the next month, leap aware.
// - Alarm, minute and frequency enables select one of five interrupt modes.
// - Alarm match drives interrupt low and holds until a status write leaves alarm mode or comes after the match minute.
// - Match lasts one minute; a status write within it re-asserts low.
// - Frequency mode outputs the configured waveform on the interrupt pin.
// - Minute edge mode latches low at carry; status write within 10 ms re-latches.
// - Minute clock mode toggles with one-minute period, half duty, after first carry.
// - A frame starts after chip select with 0110, command, then read/write bit.
// - Commands: reset, status, calendar, hour-start, alarm, test start/end; others idle.
// - Supply detect samples 15.6 ms each second; a latch waits for status read.
`ifndef BCCC_REGS_VH
`define BCCC_REGS_VH

`define BCCC_HDR          4'h6
`define BCCC_CMD_RESET    3'h0
`define BCCC_CMD_STATUS   3'h1
`define BCCC_CMD_CAL      3'h2
`define BCCC_CMD_HOUR     3'h3
`define BCCC_CMD_ALARM    3'h4
`define BCCC_CMD_TEST_ON  3'h6
`define BCCC_CMD_TEST_OFF 3'h7

`define BCCC_LEN_CAL      7'h38
`define BCCC_LEN_HOUR     7'h18
`define BCCC_LEN_STATUS   7'h08
`define BCCC_LEN_ALARM    7'h10
`define BCCC_HOUR_BASE    6'h20

`define BCCC_STAT_PWR     7
`define BCCC_STAT_24H     6
`define BCCC_STAT_AE      5
`define BCCC_STAT_ME      3
`define BCCC_STAT_FE      1
`define BCCC_STAT_RESET   8'h82
`define BCCC_ALARM_RESET  16'h8000
`define BCCC_HOUR_PM      6

`define BCCC_YEAR_INIT    8'h00
`define BCCC_MONTH_INIT   8'h01
`define BCCC_DAY_INIT     8'h01
`define BCCC_DOW_INIT     8'h00
`define BCCC_TIME_INIT    8'h00

`define BCCC_REF_HZ       10000000
`define BCCC_SUB_HZ       65536
`define BCCC_SUB_DIV      (`BCCC_REF_HZ / `BCCC_SUB_HZ)
`define BCCC_HOLD_US      10000
`define BCCC_HOLD_TICKS   ((`BCCC_HOLD_US * `BCCC_SUB_HZ) / 1000000)
`define BCCC_SAMPLE_US    15600
`define BCCC_SAMPLE_TICKS ((`BCCC_SAMPLE_US * `BCCC_SUB_HZ) / 1000000)

`endif

// ==== hdl/bccc_timebase.v ====
//////////////////////////////////////////////////////////////////////////////
// Purpose : Sub-tick divider, frequency phase counter and second tick
// Assumes : Single reference clock
// Notes   : Phase bit k runs at 32768 Hz / 2**k, bit 15 is 1 Hz
//////////////////////////////////////////////////////////////////////////////
`include "bccc_regs.vh"

module bccc_timebase #(
  parameter SUB_DIV = `BCCC_SUB_DIV
) (
  input  wire        i_clk,
  input  wire        i_reset_n,
  output reg         o_sub_tick,
  output reg         o_sec_tick,
  output reg  [15:0] o_phase
);

  localparam [31:0] DIV_FULL = SUB_DIV - 1;
  localparam [15:0] DIV_LAST = DIV_FULL[15:0];

  reg [15:0] div_r;

  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      div_r      <= 16'h0000;
      o_sub_tick <= 1'b0;
      o_sec_tick <= 1'b0;
      o_phase    <= 16'h0000;
    end
    else
    begin
      o_sub_tick <= 1'b0;
      o_sec_tick <= 1'b0;
      if (div_r == DIV_LAST)
      begin
        div_r      <= 16'h0000;
        o_sub_tick <= 1'b1;
        o_phase    <= o_phase + 16'h0001;
        o_sec_tick <= (o_phase == 16'hffff);
      end
      else
      begin
        div_r <= div_r + 16'h0001;
      end
    end
  end

endmodule // bccc_timebase

// ==== hdl/bccc_serial.v ====
//////////////////////////////////////////////////////////////////////////////
// Purpose : Three-wire serial frame engine
// Assumes : Pins asynchronous to the reference clock
// Notes   : Data bit index advances one cycle after each write strobe
//////////////////////////////////////////////////////////////////////////////
`include "bccc_regs.vh"

module bccc_serial (
  input  wire       i_clk,
  input  wire       i_reset_n,
  input  wire       i_cs,
  input  wire       i_sck,
  input  wire       i_sio,
  input  wire       i_rd_bit,
  output reg        o_cmd_stb,
  output reg  [2:0] o_cmd,
  output reg        o_rw,
  output reg        o_wr_stb,
  output reg        o_wr_bit,
  output reg  [5:0] o_idx,
  output reg        o_sio_oe
);

  reg       cs_m, cs_s, sck_m, sck_s, sck_d, sio_m, sio_s;
  reg [6:0] hdr_r;
  reg [3:0] cnt_r;
  reg       act_r;
  reg       step_r;

  wire sck_rise = sck_s & ~sck_d;
  wire sck_fall = ~sck_s & sck_d;

  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      {cs_m, cs_s, sck_m, sck_s, sck_d, sio_m, sio_s} <= 7'h1f;
      hdr_r     <= 7'h00;
      cnt_r     <= 4'h0;
      act_r     <= 1'b0;
      step_r    <= 1'b0;
      o_cmd_stb <= 1'b0;
      o_cmd     <= 3'h0;
      o_rw      <= 1'b0;
      o_wr_stb  <= 1'b0;
      o_wr_bit  <= 1'b0;
      o_idx     <= 6'h00;
      o_sio_oe  <= 1'b0;
    end
    else
    begin
      cs_m      <= i_cs;
      cs_s      <= cs_m;
      sck_m     <= i_sck;
      sck_s     <= sck_m;
      sck_d     <= sck_s;
      sio_m     <= i_sio;
      sio_s     <= sio_m;
      o_cmd_stb <= 1'b0;
      o_wr_stb  <= 1'b0;
      step_r    <= 1'b0;
      if (step_r && o_idx != 6'h3f)
        o_idx <= o_idx + 6'h01;
      if (!cs_s)
      begin
        cnt_r    <= 4'h0;
        act_r    <= 1'b0;
        o_idx    <= 6'h00;
        o_sio_oe <= 1'b0;
      end
      else if (sck_rise)
      begin
        if (cnt_r != 4'h8)
        begin
          hdr_r <= {hdr_r[5:0], sio_s};
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'h7 && hdr_r[6:3] == `BCCC_HDR)
          begin
            o_cmd_stb <= 1'b1;
            o_cmd     <= hdr_r[2:0];
            o_rw      <= sio_s;
            act_r     <= 1'b1;
          end
        end
        else if (act_r)
        begin
          // Extra clocks past the register length are ignored upstream
          o_wr_stb <= ~o_rw;
          o_wr_bit <= sio_s;
          step_r   <= 1'b1;
        end
      end
      else if (sck_fall && act_r && o_rw)
      begin
        o_sio_oe <= ~i_rd_bit;
      end
    end
  end

endmodule // bccc_serial

// ==== hdl/bccc_top.v ====
//////////////////////////////////////////////////////////////////////////////
// Purpose : BCD calendar clock core with status, alarm and interrupt pin
// Assumes : I_REF_CLK 10 MHz; serial pins and supply detector asynchronous
// Notes   : Open-drain pins only ever drive low; enables high while driving
//////////////////////////////////////////////////////////////////////////////
`include "bccc_regs.vh"

module bccc_top #(
  parameter SUB_DIV = `BCCC_SUB_DIV
) (
  input  wire I_REF_CLK,
  input  wire I_RESET_N,
  input  wire I_CS,
  input  wire I_SCK,
  input  wire I_SIO,
  input  wire I_SUPPLY_LOW,
  output reg  O_SIO,
  output wire O_SIO_OE,
  output reg  O_INT,
  output reg  O_INT_OE,
  output reg  O_DET_SAMPLE
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function [7:0] bcd_fix;
    input [7:0] v;
    input [7:0] lo;
    input [7:0] hi;
    input [7:0] dflt;
    begin
      bcd_fix = (v[3:0] <= 4'h9 && v[7:4] <= 4'h9 && v >= lo && v <= hi) ? v : dflt;
    end
  endfunction

  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    end
  endfunction

  function [7:0] days_in;
    input [7:0] m;
    input [7:0] y;
    reg         leap;
    begin
      leap = y[4] ? (y[1:0] == 2'b10) : (y[1:0] == 2'b00);
      case (m)
        8'h02:                      days_in = leap ? 8'h29 : 8'h28;
        8'h04, 8'h06, 8'h09, 8'h11: days_in = 8'h30;
        default:                    days_in = 8'h31;
      endcase
    end
  endfunction

  function [6:0] xfer_len;
    input [2:0] c;
    begin
      case (c)
        `BCCC_CMD_CAL:    xfer_len = `BCCC_LEN_CAL;
        `BCCC_CMD_HOUR:   xfer_len = `BCCC_LEN_HOUR;
        `BCCC_CMD_STATUS: xfer_len = `BCCC_LEN_STATUS;
        `BCCC_CMD_ALARM:  xfer_len = `BCCC_LEN_ALARM;
        default:          xfer_len = 7'h00;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Timebase and serial engine
  wire        sub_tick;
  wire        sec_tick;
  wire [15:0] phase;
  wire        cmd_stb;
  wire [2:0]  cmd;
  wire        rw;
  wire        wr_stb;
  wire        wr_bit;
  wire [5:0]  idx;
  reg         rd_bit;

  bccc_timebase #(.SUB_DIV(SUB_DIV)) u_timebase (
    .i_clk      (I_REF_CLK),
    .i_reset_n  (I_RESET_N),
    .o_sub_tick (sub_tick),
    .o_sec_tick (sec_tick),
    .o_phase    (phase)
  );

  bccc_serial u_serial (
    .i_clk     (I_REF_CLK),
    .i_reset_n (I_RESET_N),
    .i_cs      (I_CS),
    .i_sck     (I_SCK),
    .i_sio     (I_SIO),
    .i_rd_bit  (rd_bit),
    .o_cmd_stb (cmd_stb),
    .o_cmd     (cmd),
    .o_rw      (rw),
    .o_wr_stb  (wr_stb),
    .o_wr_bit  (wr_bit),
    .o_idx     (idx),
    .o_sio_oe  (O_SIO_OE)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [7:0]  year_r, month_r, day_r, dow_r, min_r;
  reg [5:0]  hour_r;
  reg        pm_r;
  reg [6:0]  sec_r;
  reg        test_r;
  reg [6:0]  stat_r;
  reg        pwr_r, bo_latch_r;
  reg [15:0] alarm_r;
  reg [55:0] wbuf_r, snap_r;
  reg        commit_r;
  reg [9:0]  hold_r, samp_r;
  reg        sup_m, sup_s;
  localparam [31:0] SAMP_FULL = `BCCC_SAMPLE_TICKS, HOLD_FULL = `BCCC_HOLD_TICKS;
  reg        edge_lat_r, alarm_lat_r, match_d_r, run_r;

  wire mode24 = stat_r[`BCCC_STAT_24H];
  wire ae     = stat_r[`BCCC_STAT_AE];
  wire me     = stat_r[`BCCC_STAT_ME];
  wire fe     = stat_r[`BCCC_STAT_FE];

  wire       pm_rd    = mode24 ? (hour_r >= 6'h12) : pm_r;
  wire [7:0] hour_rd  = {1'b0, pm_rd, hour_r};
  wire [55:0] cal_vec = {test_r, sec_r, min_r, hour_rd, dow_r, day_r, month_r, year_r};
  wire [7:0] stat_rd  = {pwr_r | bo_latch_r, stat_r};

  wire init_cmd = cmd_stb && cmd == `BCCC_CMD_RESET;
  wire cal_wr   = commit_r && cmd == `BCCC_CMD_CAL;
  wire hour_wr  = commit_r && cmd == `BCCC_CMD_HOUR;
  wire stat_wr  = commit_r && cmd == `BCCC_CMD_STATUS;
  wire [5:0] base = (cmd == `BCCC_CMD_HOUR) ? `BCCC_HOUR_BASE : 6'h00;
  wire [5:0] pos  = base + idx;

  // Read data is taken from a snapshot so a frame never sees a carry mid-way
  always @*
  begin
    rd_bit = 1'b1;
    if ({1'b0, idx} < xfer_len(cmd) && cmd != `BCCC_CMD_ALARM)
      rd_bit = snap_r[pos];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calendar next state
  wire        tick_en  = sec_tick & ~init_cmd & ~cal_wr & ~hour_wr;
  wire [7:0]  sec8     = {1'b0, sec_r};
  wire        sec_bad  = bcd_fix(sec8, 8'h00, 8'h59, 8'h00) != sec8;
  wire        c_min    = tick_en && (sec_bad || sec8 == 8'h59);
  wire        c_hour   = c_min && min_r == 8'h59;
  wire        c_hwrap  = c_hour && hour_r == (mode24 ? 6'h23 : 6'h11);
  wire        c_day    = c_hwrap && (mode24 || pm_r);
  wire        c_mon    = c_day && day_r >= days_in(month_r, year_r);
  wire        c_year   = c_mon && month_r == 8'h12;

  reg [7:0] year_nxt, month_nxt, day_nxt, dow_nxt, min_nxt, t8;
  reg [5:0] hour_nxt;
  reg       pm_nxt;
  reg [6:0] sec_nxt;

  always @*
  begin
    year_nxt  = year_r;
    month_nxt = month_r;
    day_nxt   = day_r;
    dow_nxt   = dow_r;
    hour_nxt  = hour_r;
    pm_nxt    = pm_r;
    min_nxt   = min_r;
    sec_nxt   = sec_r;
    t8        = 8'h00;
    if (init_cmd)
    begin
      year_nxt  = `BCCC_YEAR_INIT;
      month_nxt = `BCCC_MONTH_INIT;
      day_nxt   = `BCCC_DAY_INIT;
      dow_nxt   = `BCCC_DOW_INIT;
      hour_nxt  = 6'h00;
      pm_nxt    = 1'b0;
      min_nxt   = `BCCC_TIME_INIT;
      sec_nxt   = 7'h00;
    end
    else if (cal_wr || hour_wr)
    begin
      if (cal_wr)
      begin
        year_nxt  = bcd_fix(wbuf_r[7:0], 8'h00, 8'h99, `BCCC_YEAR_INIT);
        month_nxt = bcd_fix(wbuf_r[15:8], 8'h01, 8'h12, `BCCC_MONTH_INIT);
        day_nxt   = bcd_fix(wbuf_r[23:16], 8'h01, 8'h31, `BCCC_DAY_INIT);
        dow_nxt   = bcd_fix(wbuf_r[31:24], 8'h00, 8'h06, `BCCC_DOW_INIT);
        if (day_nxt > days_in(month_nxt, year_nxt))
        begin
          day_nxt = `BCCC_DAY_INIT;
          if (month_nxt == 8'h12)
          begin
            month_nxt = 8'h01;
            year_nxt  = (year_nxt == 8'h99) ? 8'h00 : bcd_inc(year_nxt);
          end
          else
            month_nxt = bcd_inc(month_nxt);
        end
      end
      t8       = bcd_fix({2'b00, wbuf_r[37:32]}, 8'h00, mode24 ? 8'h23 : 8'h11, 8'h00);
      hour_nxt = t8[5:0];
      pm_nxt   = mode24 ? 1'b0 : wbuf_r[32 + `BCCC_HOUR_PM];
      min_nxt  = bcd_fix(wbuf_r[47:40], 8'h00, 8'h59, `BCCC_TIME_INIT);
      sec_nxt  = wbuf_r[54:48];
    end
    else if (tick_en)
    begin
      t8      = bcd_inc(sec8);
      sec_nxt = c_min ? 7'h00 : t8[6:0];
      if (c_min)
        min_nxt = c_hour ? 8'h00 : bcd_inc(min_r);
      if (c_hour)
      begin
        t8       = bcd_inc({2'b00, hour_r});
        hour_nxt = c_hwrap ? 6'h00 : t8[5:0];
      end
      if (c_hwrap && !mode24)
        pm_nxt = ~pm_r;
      if (c_day)
      begin
        dow_nxt = (dow_r == 8'h06) ? 8'h00 : bcd_inc(dow_r);
        day_nxt = c_mon ? 8'h01 : bcd_inc(day_r);
      end
      if (c_mon)
        month_nxt = c_year ? 8'h01 : bcd_inc(month_r);
      if (c_year)
        year_nxt = (year_r == 8'h99) ? 8'h00 : bcd_inc(year_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt mode decode
  wire mode_freq  = fe & ~me;
  wire mode_edge  = me & ~fe;
  wire mode_clock = me & fe;
  wire mode_alarm = ae & ~me & ~fe;
  wire wave       = &(phase | ~alarm_r);
  wire hour_hit   = mode24 ? (alarm_r[5:0] == hour_r)
                           : ({alarm_r[`BCCC_HOUR_PM], alarm_r[5:0]} == {pm_r, hour_r});
  wire match      = ae && alarm_r[15:8] == min_r && hour_hit;
  reg  int_low_nxt;

  always @*
  begin
    case ({ae, me, fe})
      3'b001, 3'b101: int_low_nxt = ~wave;
      3'b010, 3'b110: int_low_nxt = edge_lat_r;
      3'b011, 3'b111: int_low_nxt = run_r && sec_r < 7'h30;
      3'b100:         int_low_nxt = alarm_lat_r;
      default:        int_low_nxt = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  always @(posedge I_REF_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      year_r       <= `BCCC_YEAR_INIT;
      month_r      <= `BCCC_MONTH_INIT;
      day_r        <= `BCCC_DAY_INIT;
      dow_r        <= `BCCC_DOW_INIT;
      hour_r       <= 6'h00;
      pm_r         <= 1'b0;
      min_r        <= `BCCC_TIME_INIT;
      sec_r        <= 7'h00;
      test_r       <= 1'b0;
      {pwr_r, stat_r} <= `BCCC_STAT_RESET;
      alarm_r      <= `BCCC_ALARM_RESET;
      bo_latch_r   <= 1'b0;
      wbuf_r       <= 56'h0;
      snap_r       <= 56'h0;
      commit_r     <= 1'b0;
      hold_r       <= 10'h000;
      samp_r       <= 10'h000;
      sup_m        <= 1'b0;
      sup_s        <= 1'b0;
      edge_lat_r   <= 1'b0;
      alarm_lat_r  <= 1'b0;
      match_d_r    <= 1'b0;
      run_r        <= 1'b0;
      O_SIO        <= 1'b0;
      O_INT        <= 1'b0;
      O_INT_OE     <= 1'b0;
      O_DET_SAMPLE <= 1'b0;
    end
    else
    begin
      year_r   <= year_nxt;
      month_r  <= month_nxt;
      day_r    <= day_nxt;
      dow_r    <= dow_nxt;
      hour_r   <= hour_nxt;
      pm_r     <= pm_nxt;
      min_r    <= min_nxt;
      sec_r    <= sec_nxt;
      commit_r <= 1'b0;
      sup_m    <= I_SUPPLY_LOW;
      sup_s    <= sup_m;
      // Command byte
      if (cmd_stb)
      begin
        snap_r <= (cmd == `BCCC_CMD_STATUS) ? {48'h0, stat_rd} : cal_vec;
        if (cmd == `BCCC_CMD_TEST_ON)
          test_r <= 1'b1;
        if (cmd == `BCCC_CMD_TEST_OFF || cmd == `BCCC_CMD_RESET)
          test_r <= 1'b0;
      end
      if (wr_stb && {1'b0, idx} < xfer_len(cmd))
      begin
        wbuf_r[pos] <= wr_bit;
        commit_r    <= ({1'b0, idx} == xfer_len(cmd) - 7'h01);
      end
      if (stat_wr)
        stat_r <= wbuf_r[6:0];
      if (commit_r && cmd == `BCCC_CMD_ALARM)
        alarm_r <= wbuf_r[15:0];
      // Supply detector: a set from the sampler wins over a clear
      if (sec_tick && !bo_latch_r)
        samp_r <= SAMP_FULL[9:0];
      else if (bo_latch_r || (sub_tick && samp_r != 10'h000))
        samp_r <= bo_latch_r ? 10'h000 : samp_r - 10'h001;
      if (samp_r != 10'h000 && !bo_latch_r && sup_s)
        bo_latch_r <= 1'b1;
      else if (cmd_stb && cmd == `BCCC_CMD_STATUS && rw)
        bo_latch_r <= 1'b0;
      else if (init_cmd)
        bo_latch_r <= 1'b0;
      if (cmd_stb && cmd == `BCCC_CMD_STATUS && rw && bo_latch_r)
        pwr_r <= 1'b1;
      else if (init_cmd)
        pwr_r <= 1'b0;
      O_DET_SAMPLE <= samp_r != 10'h000 && !bo_latch_r;
      // Minute carry retention window
      if (c_min)
        hold_r <= HOLD_FULL[9:0];
      else if (sub_tick && hold_r != 10'h000)
        hold_r <= hold_r - 10'h001;
      if (c_min && mode_edge)
        edge_lat_r <= 1'b1;
      else if (stat_wr)
        edge_lat_r <= hold_r != 10'h000;
      match_d_r <= match;
      if (match && !match_d_r && mode_alarm)
        alarm_lat_r <= 1'b1;
      else if (stat_wr)
        alarm_lat_r <= match;
      if (!mode_clock)
        run_r <= 1'b0;
      else if (c_min)
        run_r <= 1'b1;
      O_INT_OE <= int_low_nxt && !(mode_freq && alarm_r == 16'h0000);
    end
  end

endmodule // bccc_top

// ==== bench/bccc_checker.sv ====
// Purpose : Port-level checks of the calendar clock core
// Assumes : Sees only the top ports; one clock domain
// Notes   : Rise counting uses pin samples, so the header check lags by a clock
////////////////////////////////////////////////////////////////////////////////
module bccc_checker #(
  parameter SUB_DIV = 1
) (
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  input wire logic I_CS,
  input wire logic I_SCK,
  input wire logic I_SIO,
  input wire logic I_SUPPLY_LOW,
  input wire logic O_SIO,
  input wire logic O_SIO_OE,
  input wire logic O_INT,
  input wire logic O_INT_OE,
  input wire logic O_DET_SAMPLE
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DET_MAX = 1023;
  localparam int GAP_MIN = 30000;
  logic       sck_r;
  logic       rw_r;
  logic [3:0] rise_cnt_r;
  int         det_cnt_r;
  int         gap_cnt_r;
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESET_N);
  always @(posedge I_REF_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      sck_r      <= 1'b1;
      rw_r       <= 1'b0;
      rise_cnt_r <= 4'h0;
      det_cnt_r  <= 0;
      gap_cnt_r  <= 0;
    end
    else
    begin
      sck_r <= I_SCK;
      if (!I_CS)
        rise_cnt_r <= 4'h0;
      else if (I_SCK && !sck_r && rise_cnt_r != 4'hf)
        rise_cnt_r <= rise_cnt_r + 4'h1;
      if (I_CS && I_SCK && !sck_r && rise_cnt_r == 4'h7)
        rw_r <= I_SIO;
      det_cnt_r <= O_DET_SAMPLE ? det_cnt_r + 1 : 0;
      gap_cnt_r <= (O_DET_SAMPLE && det_cnt_r == 0) ? 0 : gap_cnt_r + 1;
    end
  end
  a_sio_low_only: assert property (O_SIO == 1'b0)
    else $error("data pin drive value not low");
  a_int_low_only: assert property (O_INT == 1'b0)
    else $error("interrupt drive value not low");
  a_sio_idle: assert property ((!I_CS) [*4] |-> !O_SIO_OE)
    else $error("data pin driven while deselected");
  a_sio_on_fall: assert property ($rose(O_SIO_OE) |-> !$past(I_SCK, 2))
    else $error("read bit not launched by a clock fall");
  a_det_length: assert property (O_DET_SAMPLE |-> det_cnt_r <= DET_MAX * SUB_DIV)
    else $error("detector window too long");
  a_det_spacing: assert property ($rose(O_DET_SAMPLE) |-> gap_cnt_r >= GAP_MIN * SUB_DIV)
    else $error("detector windows too close");
  a_sio_header: assert property (I_CS && rise_cnt_r < 4'h8 |-> !O_SIO_OE)
    else $error("data pin driven during header");
  a_sio_write: assert property (I_CS && rise_cnt_r >= 4'h8 && !rw_r |-> !O_SIO_OE)
    else $error("data pin driven during a write");
endmodule // bccc_checker

bind bccc_top bccc_checker #(.SUB_DIV(SUB_DIV)) i_bccc_checker (
  .I_REF_CLK(I_REF_CLK), .I_RESET_N(I_RESET_N), .I_CS(I_CS), .I_SCK(I_SCK),
  .I_SIO(I_SIO), .I_SUPPLY_LOW(I_SUPPLY_LOW), .O_SIO(O_SIO), .O_SIO_OE(O_SIO_OE),
  .O_INT(O_INT), .O_INT_OE(O_INT_OE), .O_DET_SAMPLE(O_DET_SAMPLE));

// ==== bench/bccc_host_model.sv ====
// Purpose : Host model driving the three-wire link
// Assumes : Data line pulled up; both ends only pull it low
// Notes   : Clock phases are 4 reference clocks, an 800 ns period
////////////////////////////////////////////////////////////////////////////////
module bccc_host_model (
  input  wire logic i_clk,
  input  wire logic i_sio,
  output logic      o_cs,
  output logic      o_sck,
  output logic      o_sio_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_cs      = 1'b0;
    o_sck     = 1'b1;
    o_sio_low = 1'b0;
  end
  // Read bits are taken late in the high phase, clear of the launch lag
  task xfer(input logic [2:0] cmd, input logic rw, input int n,
            input logic [55:0] wd, output logic [55:0] rd);
    logic [63:0] b;
    b  = {wd, rw, cmd[0], cmd[1], cmd[2], 4'b0110};
    rd = '0;
    o_cs <= 1'b1;
    repeat (4) @(posedge i_clk);
    for (int k = 0; k < 8 + n; k++)
    begin
      o_sck     <= 1'b0;
      o_sio_low <= (k < 8 || !rw) && !b[k];
      repeat (4) @(posedge i_clk);
      o_sck <= 1'b1;
      repeat (4) @(posedge i_clk);
      if (k >= 8)
        rd[k - 8] = i_sio;
    end
    o_cs      <= 1'b0;
    o_sio_low <= 1'b0;
    repeat (6) @(posedge i_clk);
  endtask
endmodule // bccc_host_model

// ==== bench/tb_top.sv ====
// Purpose : Self-checking bench of the calendar clock core
// Assumes : SUB_DIV of 1, so one second is 65536 clocks
// Notes   : Only one second carry fits in the run
////////////////////////////////////////////////////////////////////////////////
`include "bccc_regs.vh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sup_low = 1'b0;
  wire         cs, sck, host_low, o_sio, o_sio_oe, o_int, o_int_oe, o_det;
  wire         sio_w = ~(host_low | o_sio_oe);
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cnt;
  logic [55:0] rd, w;
  logic [15:0] masks [5];
  logic [7:0]  v;
  always #50 clk = ~clk;
  bccc_top #(.SUB_DIV(1)) i_bccc_top (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_CS(cs),
    .I_SCK(sck), .I_SIO(sio_w), .I_SUPPLY_LOW(sup_low), .O_SIO(o_sio),
    .O_SIO_OE(o_sio_oe), .O_INT(o_int), .O_INT_OE(o_int_oe), .O_DET_SAMPLE(o_det));
  bccc_host_model i_bccc_host_model (.i_clk(clk), .i_sio(sio_w), .o_cs(cs),
    .o_sck(sck), .o_sio_low(host_low));
  function automatic logic ok(logic [7:0] x, logic [7:0] hi);
    return x[3:0] <= 4'h9 && x <= hi;
  endfunction
  function automatic logic [7:0] bcd(int x);
    return 8'((x / 10 % 10) * 16 + x % 10);
  endfunction
  function automatic logic [55:0] exp_cal(logic [55:0] c);
    logic [7:0] y, mo, d, dw, h, mi, s, mx;
    {s, mi, h, dw, d, mo, y} = c;
    y    = ok(y, 8'h99) ? y : 8'h00;
    mo   = ok(mo, 8'h12) && mo != 8'h00 ? mo : 8'h01;
    d    = ok(d, 8'h31) && d != 8'h00 ? d : 8'h01;
    dw   = dw <= 8'h06 ? dw : 8'h00;
    h    = ok(h & 8'h3f, 8'h23) ? h & 8'h3f : 8'h00;
    h[6] = h >= 8'h12;
    mi   = ok(mi, 8'h59) ? mi : 8'h00;
    mx   = mo == 8'h02 ? ((y[7:4] * 10 + y[3:0]) % 4 == 0 ? 8'h29 : 8'h28) :
           (mo == 8'h04 || mo == 8'h06 || mo == 8'h09 || mo == 8'h11) ? 8'h30 : 8'h31;
    if (d > mx)
    begin
      d  = 8'h01;
      mo = mo == 8'h09 ? 8'h10 : mo + 8'h01;
    end
    return {s, mi, h, dw, d, mo, y};
  endfunction
  task x(input logic [2:0] c, input logic r, input int n, input logic [55:0] d);
    i_bccc_host_model.xfer(c, r, n, d, rd);
  endtask
  task stat(input logic [7:0] e);
    x(`BCCC_CMD_STATUS, 1'b1, 8, 56'h0);
    `CHK(rd[7:0], e)
  endtask
  task done(input string s);
    $display("test %s done", s);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (90000) @(posedge clk);
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test();
  end
  initial
  begin
    void'($urandom(97));
    masks = '{16'h0000, 16'h0001, 16'h0006, 16'h0019, 16'h0000};
    masks[4] = 16'($urandom & 32'h1f);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    stat(8'h82);
    x(`BCCC_CMD_RESET, 1'b0, 0, 56'h0);
    stat(8'h02);
    x(`BCCC_CMD_CAL, 1'b1, 56, 56'h0);
    `CHK(rd, 56'h00000000010100)
    v = 8'($urandom);
    x(`BCCC_CMD_STATUS, 1'b0, 8, v);
    stat({1'b0, v[6:0]});
    x(3'h5, 1'b0, 8, 56'hff);
    stat({1'b0, v[6:0]});
    x(`BCCC_CMD_ALARM, 1'b1, 16, 56'h0);
    `CHK(rd[15:0], 16'hffff)
    done("registers");
    x(`BCCC_CMD_STATUS, 1'b0, 8, 56'h40);
    for (int i = 0; i < 8; i++)
    begin
      case (i)
        0: w = 56'h006a240732139a;
        1: w = 56'h15301203300223;
        2: w = 56'h59592306290224;
        3: w = 56'h00000000290223;
        4: w = 56'h01024501310499;
        default: w = {bcd($urandom % 60), bcd($urandom % 61),
                      bcd($urandom % 24) | 8'($urandom & 64), 8'($urandom % 8),
                      bcd($urandom % 32), bcd($urandom % 13), bcd($urandom % 100)};
      endcase
      x(`BCCC_CMD_CAL, 1'b0, 56, w);
      x(`BCCC_CMD_CAL, 1'b1, 56, 56'h0);
      `CHK(rd, exp_cal(w))
    end
    done("calendar");
    x(`BCCC_CMD_TEST_ON, 1'b0, 0, 56'h0);
    x(`BCCC_CMD_HOUR, 1'b1, 24, 56'h0);
    `CHK(rd[23], 1'b1)
    x(`BCCC_CMD_TEST_OFF, 1'b0, 0, 56'h0);
    x(`BCCC_CMD_HOUR, 1'b1, 24, 56'h0);
    `CHK(rd[23], 1'b0)
    done("test flag");
    x(`BCCC_CMD_STATUS, 1'b0, 8, 56'h42);
    for (int i = 0; i < 6; i++)
    begin
      if (i == 5)
        x(`BCCC_CMD_STATUS, 1'b0, 8, 56'h40);
      x(`BCCC_CMD_ALARM, 1'b0, 16, i == 5 ? 56'h1f : 56'(masks[i % 5]));
      repeat (8) @(posedge clk);
      cnt = 0;
      repeat (64) @(posedge clk) cnt += (o_int_oe === 1'b1);
      `CHK(cnt, (i == 5 || masks[i % 5] == 0) ? 0 : 64 - (64 >> $countones(masks[i % 5])))
    end
    done("frequency");
    x(`BCCC_CMD_ALARM, 1'b0, 16, 56'h0002);
    x(`BCCC_CMD_HOUR, 1'b0, 24, 56'h605901);
    x(`BCCC_CMD_STATUS, 1'b0, 8, 56'h60);
    `CHK(o_int_oe, 1'b0)
    sup_low <= 1'b1;
    cnt = 0;
    while (o_int_oe !== 1'b1 && cnt < 70000)
    begin
      @(posedge clk);
      cnt++;
    end
    `CHK(o_int_oe, 1'b1)
    x(`BCCC_CMD_HOUR, 1'b1, 24, 56'h0);
    `CHK(rd[23:0], 24'h000002)
    sup_low <= 1'b0;
    x(`BCCC_CMD_STATUS, 1'b0, 8, 56'h40);
    `CHK(o_int_oe, 1'b0)
    stat(8'hc0);
    done("alarm");
    end_of_test();
  end
endmodule // tb_top
